// *** logic/tbls_demap.sv ***
`timescale 1ns/1ps
module tbls_demap (
    input  wire logic                                                   clk,
    input  wire logic                                                   nrst,
    input  wire logic [tbls_pkg::FORMAT_BITS-1:0]                       link_format_select,
    input  wire logic                                                   lane_valid,
    output logic                                                        lane_ready,
    input  wire logic [tbls_pkg::LANE_COUNT-1:0][tbls_pkg::LANE_BITS-1:0] lane_data,
    output logic                                                        sample_valid,
    input  wire logic                                                   sample_ready,
    output logic [tbls_pkg::MAX_INPHASE-1:0][tbls_pkg::SAMPLE_BITS-1:0] chan_zero_inphase,
    output logic [tbls_pkg::MAX_QUAD-1:0][tbls_pkg::SAMPLE_BITS-1:0]    chan_zero_quadrature,
    output logic [tbls_pkg::COUNT_BITS-1:0]                             sample_count,
    output logic                                                        quad_present,
    output logic                                                        format_bad
);
    import tbls_pkg::*;

    typedef struct packed {
        tbls_entry_t head;
        tbls_entry_t skid;
        logic        head_v;
        logic        skid_v;
    } tbls_state_t;

    tbls_state_t st;
    tbls_state_t next_st;
    tbls_entry_t unpacked;
    logic        accept;
    logic        load_direct;

    // ------------------------------------------------------------
    // unpacking of one lane word
    // ------------------------------------------------------------
    function automatic tbls_entry_t demap(
        input logic [FORMAT_BITS-1:0]                   fmt,
        input logic [LANE_COUNT-1:0][LANE_BITS-1:0]     ln
    );
        tbls_entry_t             e;
        logic [FRAME_BITS-1:0]   a;
        logic [FRAME_BITS-1:0]   b;
        logic [FRAME_BITS-1:0]   c;
        e = '0;
        unique case (fmt)
            FMT_WIDE_TAIL: begin
                e.count = CNT_WIDE_TAIL;
                for (int l = 0; l < LANE_COUNT; l++) begin
                    for (int s = 0; s < SLOTS; s++) begin
                        // bits [3:0] are the tail nibble and never read
                        e.inph[l + LANE_COUNT*s] = ln[l][LANE_BITS-1-SAMPLE_BITS*s -: SAMPLE_BITS];
                    end
                end
            end
            FMT_PACKED: begin
                e.count = CNT_PACKED;
                for (int f = 0; f < PACK_FRAMES; f++) begin
                    for (int g = 0; g < PACK_GROUPS; g++) begin
                        a = ln[3*g][LANE_BITS-1-FRAME_BITS*f -: FRAME_BITS];
                        b = ln[3*g+1][LANE_BITS-1-FRAME_BITS*f -: FRAME_BITS];
                        c = ln[3*g+2][LANE_BITS-1-FRAME_BITS*f -: FRAME_BITS];
                        e.inph[16*f + 4*g]     = a[15:4];
                        e.inph[16*f + 4*g + 1] = {a[3:0], b[15:8]};
                        e.inph[16*f + 4*g + 2] = {b[7:0], c[15:12]};
                        e.inph[16*f + 4*g + 3] = c[11:0];
                    end
                end
            end
            FMT_COMPLEX: begin
                e.count    = CNT_COMPLEX;
                e.has_quad = 1'b1;
                for (int k = 0; k < HALF_LANES; k++) begin
                    for (int s = 0; s < SLOTS; s++) begin
                        e.inph[k + HALF_LANES*s] = ln[k][LANE_BITS-1-SAMPLE_BITS*s -: SAMPLE_BITS];
                        e.quad[k + HALF_LANES*s] =
                            ln[k+HALF_LANES][LANE_BITS-1-SAMPLE_BITS*s -: SAMPLE_BITS];
                    end
                end
            end
            default: begin
                e.bad_format = 1'b1;
            end
        endcase
        return e;
    endfunction

    // ------------------------------------------------------------
    // two-entry buffer toward the converter datapath
    // ------------------------------------------------------------
    assign lane_ready  = !st.skid_v;
    assign accept      = lane_valid && lane_ready;
    assign load_direct = accept && (!st.head_v || sample_ready);
    assign unpacked    = demap(link_format_select, lane_data);

    always_comb begin
        next_st = st;
        if (!st.head_v || sample_ready) begin
            if (st.skid_v) begin
                next_st.head   = st.skid;
                next_st.skid_v = 1'b0;
            end else if (accept) begin
                next_st.head   = unpacked;
                next_st.head_v = 1'b1;
            end else begin
                next_st.head_v = 1'b0;
            end
        end else if (accept) begin
            // receiver stalled: park the word instead of dropping it
            next_st.skid   = unpacked;
            next_st.skid_v = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sample_valid         = st.head_v;
    assign chan_zero_inphase    = st.head.inph;
    assign chan_zero_quadrature = st.head.quad;
    assign sample_count         = st.head.count;
    assign quad_present         = st.head.has_quad;
    assign format_bad           = st.head.bad_format;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_load(logic [FORMAT_BITS-1:0] fmt);
        load_direct && link_format_select == fmt;
    endsequence

    sequence s_stall;
        sample_valid && !sample_ready;
    endsequence

    AST_WIDE_COUNT: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_WIDE_TAIL) |=> sample_valid && sample_count == CNT_WIDE_TAIL && !quad_present)
        else $error("format eight count wrong");

    AST_WIDE_SLOTS: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_WIDE_TAIL) |=> chan_zero_inphase[17] == $past(lane_data[1][51:40])
            && chan_zero_inphase[79] == $past(lane_data[15][15:4]))
        else $error("format eight slot placement wrong");

    AST_WIDE_EDGES: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_WIDE_TAIL) |=> chan_zero_inphase[0] == $past(lane_data[0][63:52])
            && chan_zero_inphase[64] == $past(lane_data[0][15:4]))
        else $error("format eight first or last slot wrong");

    AST_PACKED_COUNT: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_PACKED) |=> sample_count == CNT_PACKED && !quad_present && !format_bad)
        else $error("format nine count wrong");

    AST_PACKED_SPLIT: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_PACKED) |=> chan_zero_inphase[5] == {$past(lane_data[3][51:48]), $past(lane_data[4][63:56])}
            && chan_zero_inphase[22] == {$past(lane_data[4][39:32]), $past(lane_data[5][47:44])})
        else $error("format nine split sample wrong");

    AST_PACKED_EDGES: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_PACKED) |=> chan_zero_inphase[0] == $past(lane_data[0][63:52])
            && chan_zero_inphase[63] == $past(lane_data[11][11:0]))
        else $error("format nine first or last sample wrong");

    AST_COMPLEX_HALVES: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_COMPLEX) |=> quad_present && sample_count == CNT_COMPLEX
            && chan_zero_quadrature[0] == $past(lane_data[8][63:52]))
        else $error("format ten halves wrong");

    AST_COMPLEX_SLOTS: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_COMPLEX) |=> chan_zero_quadrature[9] == $past(lane_data[9][51:40])
            && chan_zero_inphase[33] == $past(lane_data[1][15:4]))
        else $error("format ten slot placement wrong");

    AST_COMPLEX_EDGES: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_COMPLEX) |=> chan_zero_quadrature[39] == $past(lane_data[15][15:4])
            && chan_zero_inphase[0] == $past(lane_data[0][63:52]))
        else $error("format ten last quadrature slot wrong");

    AST_TAIL_DROPPED: assert property (@(posedge clk) disable iff (!nrst)
        s_load(FMT_COMPLEX) ##1 (s_load(FMT_COMPLEX) ##0 $stable(lane_data[7][63:4]))
            |=> $stable(chan_zero_inphase[39]))
        else $error("tail nibble leaked into a sample");

    AST_STALL_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
        s_stall |=> sample_valid && $stable(chan_zero_inphase) && $stable(sample_count))
        else $error("output changed while stalled");

    AST_FULL_BLOCKS: assert property (@(posedge clk) disable iff (!nrst)
        s_stall ##0 accept |=> !lane_ready)
        else $error("buffer full not reported");

    // ------------------------------------------------------------
    // buffer and unsupported-format checks
    // ------------------------------------------------------------
    sequence s_full;
        !lane_ready && sample_valid;
    endsequence

    AST_RESET_EMPTY: assert property (@(posedge clk)
        !nrst |=> !sample_valid && lane_ready && sample_count == CNT_NONE)
        else $error("buffer not empty after reset");

    AST_BAD_FORMAT: assert property (@(posedge clk) disable iff (!nrst)
        load_direct && link_format_select != FMT_WIDE_TAIL && link_format_select != FMT_PACKED
            && link_format_select != FMT_COMPLEX |=> format_bad && sample_count == CNT_NONE && !quad_present)
        else $error("unsupported format not flagged");

    AST_FULL_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
        s_full ##0 !sample_ready |=> !lane_ready && sample_valid)
        else $error("full buffer released while stalled");

    AST_SKID_DRAIN: assert property (@(posedge clk) disable iff (!nrst)
        s_full ##0 sample_ready |=> sample_valid && lane_ready)
        else $error("parked word not moved to head");

endmodule

// *** common/tbls_pkg.sv ***
package tbls_pkg;

    localparam int LANE_COUNT   = 16;
    localparam int LANE_BITS    = 64;
    localparam int SAMPLE_BITS  = 12;
    localparam int MAX_INPHASE  = 80;
    localparam int MAX_QUAD     = 40;
    localparam int SLOTS        = 5;
    localparam int HALF_LANES   = 8;
    localparam int PACK_GROUPS  = 4;
    localparam int PACK_FRAMES  = 4;
    localparam int FRAME_BITS   = 16;
    localparam int FORMAT_BITS  = 5;
    localparam int COUNT_BITS   = 7;

    // link format codes handled here
    localparam logic [FORMAT_BITS-1:0] FMT_WIDE_TAIL  = 5'h08;
    localparam logic [FORMAT_BITS-1:0] FMT_PACKED     = 5'h09;
    localparam logic [FORMAT_BITS-1:0] FMT_COMPLEX    = 5'h0a;

    // samples carried per lane word in each format
    localparam logic [COUNT_BITS-1:0] CNT_WIDE_TAIL   = 7'h50;
    localparam logic [COUNT_BITS-1:0] CNT_PACKED      = 7'h40;
    localparam logic [COUNT_BITS-1:0] CNT_COMPLEX     = 7'h28;
    localparam logic [COUNT_BITS-1:0] CNT_NONE        = 7'h00;

    typedef struct packed {
        logic [MAX_INPHASE-1:0][SAMPLE_BITS-1:0] inph;
        logic [MAX_QUAD-1:0][SAMPLE_BITS-1:0]    quad;
        logic [COUNT_BITS-1:0]                   count;
        logic                                    has_quad;
        logic                                    bad_format;
    } tbls_entry_t;

endpackage

// *** dv/tbls_tx_model.sv ***
`timescale 1ns/1ps
module tbls_tx_model (
    input  wire logic                                                   go,
    input  wire logic [tbls_pkg::FORMAT_BITS-1:0]                       fmt,
    input  wire logic [3:0]                                             tail,
    input  wire logic [tbls_pkg::MAX_INPHASE-1:0][tbls_pkg::SAMPLE_BITS-1:0] si,
    input  wire logic [tbls_pkg::MAX_QUAD-1:0][tbls_pkg::SAMPLE_BITS-1:0]    sq,
    output logic                                                        lane_valid,
    output logic [tbls_pkg::LANE_COUNT-1:0][tbls_pkg::LANE_BITS-1:0]    lane_data
);
    import tbls_pkg::*;
    logic [LANE_COUNT-1:0][LANE_BITS-1:0] d;
    assign lane_valid = go;
    // idle lanes show the inverse of the packed word
    assign lane_data = go ? d : ~d;
    always_comb begin
        d = {LANE_COUNT{si[0], si[1], si[2], si[3], 16'hdead}};
        for (int n = 0; n < LANE_COUNT; n++) begin
            for (int s = 0; s < SLOTS; s++) begin
                if (fmt == FMT_WIDE_TAIL) d[n][63-12*s -: 12] = si[n+16*s];
                if (fmt == FMT_COMPLEX) d[n][63-12*s -: 12] = (n < 8) ? si[n+8*s] : sq[n-8+8*s];
            end
            d[n][3:0] = tail;
        end
        if (fmt == FMT_PACKED) begin
            for (int f = 0; f < PACK_FRAMES; f++) begin
                for (int g = 0; g < PACK_GROUPS; g++) begin
                    {d[3*g][63-16*f -: 16], d[3*g+1][63-16*f -: 16], d[3*g+2][63-16*f -: 16]} =
                        {si[16*f+4*g], si[16*f+4*g+1], si[16*f+4*g+2], si[16*f+4*g+3]};
                end
            end
        end
    end
endmodule

// *** dv/twelve_bit_lane_sample_demap_tb.sv ***
`timescale 1ns/1ps
module twelve_bit_lane_sample_demap_tb;
    import tbls_pkg::*;
    logic clk = 0, nrst = 0, go = 0, stall = 1, burst = 0, sample_ready = 0, lane_valid, lane_ready, sample_valid;
    logic quad_present, format_bad;
    logic [FORMAT_BITS-1:0] fmt = FMT_WIDE_TAIL;
    logic [3:0] tail = 4'h0;
    logic [MAX_INPHASE-1:0][SAMPLE_BITS-1:0] si = '0, chan_zero_inphase;
    logic [MAX_QUAD-1:0][SAMPLE_BITS-1:0] sq = '0, chan_zero_quadrature;
    logic [LANE_COUNT-1:0][LANE_BITS-1:0] lane_data;
    logic [COUNT_BITS-1:0] sample_count;
    tbls_entry_t exp_q[$];
    int fail_count = 0, compares = 0, cycles = 0;
    logic [FORMAT_BITS-1:0] fmts[4] = '{FMT_WIDE_TAIL, FMT_PACKED, FMT_COMPLEX, 5'h1f};
    tbls_tx_model tx_u (.go(go), .fmt(fmt), .tail(tail), .si(si), .sq(sq), .lane_valid(lane_valid),
        .lane_data(lane_data));
    tbls_demap dut_u (.clk(clk), .nrst(nrst), .link_format_select(fmt), .lane_valid(lane_valid),
        .lane_ready(lane_ready), .lane_data(lane_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .chan_zero_inphase(chan_zero_inphase),
        .chan_zero_quadrature(chan_zero_quadrature), .sample_count(sample_count),
        .quad_present(quad_present), .format_bad(format_bad));
    initial forever #50 clk = ~clk;
    function automatic tbls_entry_t expect_of(input logic [FORMAT_BITS-1:0] f);
        tbls_entry_t e;
        e.inph = si;
        e.quad = (f == FMT_COMPLEX) ? sq : '0;
        e.count = (f == FMT_WIDE_TAIL) ? CNT_WIDE_TAIL : (f == FMT_PACKED) ? CNT_PACKED :
            (f == FMT_COMPLEX) ? CNT_COMPLEX : CNT_NONE;
        e.has_quad = (f == FMT_COMPLEX);
        e.bad_format = (f != FMT_WIDE_TAIL) && (f != FMT_PACKED) && (f != FMT_COMPLEX);
        return e;
    endfunction
    task automatic chk_bit(input logic got, input logic want, input string what);
        compares++;
        if (got !== want) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic chk_word(input tbls_entry_t e);
        logic ok;
        compares++;
        ok = (sample_count === e.count) && (quad_present === e.has_quad) && (format_bad === e.bad_format);
        for (int i = 0; i < e.count; i++) ok &= (chan_zero_inphase[i] === e.inph[i]);
        ok &= (chan_zero_quadrature === e.quad);
        if (!ok) begin
            fail_count++;
            $display("[ERR] %0t sample entry mismatch", $time);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // offer one word on the current edge; the word stays up until taken
    task automatic offer(input logic [FORMAT_BITS-1:0] f, input logic [3:0] t, input logic keep);
        logic [MAX_INPHASE-1:0][SAMPLE_BITS-1:0] ri;
        logic [MAX_QUAD-1:0][SAMPLE_BITS-1:0] rq;
        // keep repeats the previous samples so that only the tail differs
        for (int i = 0; i < MAX_INPHASE; i++) ri[i] = keep ? si[i] : SAMPLE_BITS'($urandom);
        for (int i = 0; i < MAX_QUAD; i++) rq[i] = keep ? sq[i] : SAMPLE_BITS'($urandom);
        go <= 1'b1;
        fmt <= f;
        tail <= t;
        si <= ri;
        sq <= rq;
        #1 exp_q.push_back(expect_of(f));
    endtask
    task automatic wait_take();
        do @(posedge clk); while (!lane_ready);
    endtask
    task automatic drain();
        while (exp_q.size() > 0) @(posedge clk);
        repeat (2) @(posedge clk);
        chk_bit(sample_valid, 1'b0, "buffer not empty after drain");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (nrst && sample_valid && sample_ready) chk_word(exp_q.pop_front());
        sample_ready <= stall ? 1'b0 : (burst ? 1'b1 : 1'($urandom));
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(28425));
        repeat (10) @(posedge clk);
        chk_bit(sample_valid, 1'b0, "valid out of reset");
        chk_bit(lane_ready, 1'b1, "ready out of reset");
        nrst <= 1'b1;
        $display("test reset done");
        offer(FMT_WIDE_TAIL, 4'hf, 1'b0);
        wait_take();
        offer(FMT_PACKED, 4'h5, 1'b0);
        wait_take();
        offer(FMT_COMPLEX, 4'ha, 1'b0);
        repeat (3) @(posedge clk);
        chk_bit(lane_ready, 1'b0, "third word not refused");
        stall <= 1'b0;
        wait_take();
        $display("test fill and refuse done");
        for (int k = 0; k < 300; k++) begin
            offer(fmts[$urandom % 4], 4'($urandom), 1'b0);
            wait_take();
        end
        go <= 1'b0;
        stall <= 1'b1;
        repeat (5) @(posedge clk);
        stall <= 1'b0;
        drain();
        $display("test random stream done");
        burst <= 1'b1;
        offer(FMT_COMPLEX, 4'h3, 1'b0);
        wait_take();
        offer(FMT_COMPLEX, 4'hc, 1'b1);
        wait_take();
        go <= 1'b0;
        drain();
        $display("test tail discard done");
        wrap_up();
    end
endmodule
